// *** src/vms_mode_status.sv ***
// mode capture, shared pin roles, enables, straps, pulse limit and power good
// assumes all pins are synchronous to mclk; the serial protocol engine sits outside
`default_nettype none
module vms_mode_status (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // system control
  input  wire logic                 enable_in,
  input  wire logic                 system_power_ok,
  input  wire logic                 frequency_set_strap,
  input  wire logic [4:1]           current_sense_neg_at_supply,
  // shared code pins
  input  wire logic                 mode_select_code_bit1,
  input  wire logic                 fixed_mode_sel_code_bit0,
  input  wire logic                 serial_data_code_bit2_in,
  output logic                      serial_data_code_bit2_out,
  output logic                      serial_data_code_bit2_oe,
  input  wire logic                 serial_clock_code_bit3,
  input  wire logic                 parallel_code_bit4,
  input  wire logic                 parallel_code_bit5,
  // serial engine side
  input  wire logic                 link_data_out,
  input  wire logic                 link_data_drive,
  output logic                      link_data_in,
  output logic                      link_clock_in,
  // analog core side
  input  wire logic                 soft_start_done,
  input  wire logic                 window_fault,
  input  wire logic                 reset_event,
  input  wire logic [4:1]           pwm_demand,
  output logic                      core_enable,
  output logic                      nb_enable,
  output logic [5:0]                ref_code,
  output logic [1:0]                boot_code,
  output vms_pkg::vms_status_s      status,
  output logic [2:1]                phase_pulse_out,
  output logic                      phase3_pulse_out,
  output logic                      phase4_pulse_out,
  output logic                      outputs_power_good
);
  // ------------------------------------------------------------
  // enable edge and mode capture
  // ------------------------------------------------------------
  logic                 en_q;
  vms_pkg::vms_mode_e   mode;
  vms_pkg::vms_state_e  state;
  vms_pkg::vms_pins_s   pins;
  logic                 serial_active;
  logic                 en_rise;

  assign en_rise = enable_in & ~en_q;
  assign pins = '{bit5: parallel_code_bit5, bit4: parallel_code_bit4,
                  bit3: serial_clock_code_bit3, bit2: serial_data_code_bit2_in,
                  bit1: mode_select_code_bit1, bit0: fixed_mode_sel_code_bit0};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= enable_in;
    end
  end

  // only the rising edge loads, so the mode is frozen for the whole enabled span
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode <= vms_pkg::MODE_SERIAL;
    end else if (en_rise) begin
      mode <= pins.bit1 ? vms_pkg::MODE_PARALLEL : vms_pkg::MODE_SERIAL;
    end
  end

  // ------------------------------------------------------------
  // regulator sequencing
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= vms_pkg::ST_OFF;
    end else if (!enable_in) begin
      state <= vms_pkg::ST_OFF;
    end else begin
      unique case (state)
        vms_pkg::ST_OFF: begin
          state <= vms_pkg::ST_SOFT;
        end
        vms_pkg::ST_SOFT: begin
          if (soft_start_done) begin
            state <= vms_pkg::ST_ON;
          end
        end
        vms_pkg::ST_ON: begin
          state <= vms_pkg::ST_ON;
        end
        default: begin
          state <= vms_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      core_enable <= 1'b0;
      nb_enable   <= 1'b0;
    end else begin
      core_enable <= enable_in;
      nb_enable   <= enable_in;
    end
  end

  // ------------------------------------------------------------
  // shared pin roles
  // ------------------------------------------------------------
  assign serial_active = en_q & (mode == vms_pkg::MODE_SERIAL);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_code  <= vms_pkg::REF_CODE_RST;
      boot_code <= vms_pkg::BOOT_CODE_RST;
    end else if (en_q && mode == vms_pkg::MODE_PARALLEL) begin
      ref_code <= {pins.bit5, pins.bit4, pins.bit3,
                   pins.bit2, pins.bit1, pins.bit0};
    end else if (serial_active && !system_power_ok) begin
      boot_code <= {pins.bit2, pins.bit3};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status <= '{mode: vms_pkg::MODE_SERIAL, fixed_voltage_mode: 1'b0,
                  serial_run: 1'b0, droop_en: 1'b0, phase_count: vms_pkg::PHASES_FOUR};
    end else begin
      status.mode               <= mode;
      status.fixed_voltage_mode <= serial_active & pins.bit0;
      status.serial_run         <= serial_active & system_power_ok;
      status.droop_en           <= frequency_set_strap;
      status.phase_count        <= current_sense_neg_at_supply[3] ? vms_pkg::PHASES_TWO :
                                   current_sense_neg_at_supply[4] ? vms_pkg::PHASES_THREE :
                                   vms_pkg::PHASES_FOUR;
    end
  end

  // data line: drive only while the link runs; the processor as master owns the rest
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      serial_data_code_bit2_out <= 1'b0;
      serial_data_code_bit2_oe  <= 1'b0;
      link_data_in              <= 1'b0;
      link_clock_in             <= 1'b0;
    end else begin
      serial_data_code_bit2_out <= link_data_out;
      serial_data_code_bit2_oe  <= serial_active & system_power_ok & link_data_drive;
      link_data_in              <= serial_active & pins.bit2;
      link_clock_in             <= serial_active & pins.bit3;
    end
  end

  // ------------------------------------------------------------
  // per-channel pulse limit
  // ------------------------------------------------------------
  logic [vms_pkg::CNT_W-1:0] period_cnt;
  logic [4:1]                chan_pulse;
  logic [4:1]                chan_allowed;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      period_cnt <= vms_pkg::CNT_RST;
    end else if (period_cnt == vms_pkg::PERIOD_LAST) begin
      period_cnt <= vms_pkg::CNT_RST;
    end else begin
      period_cnt <= period_cnt + 8'h01;
    end
  end

  assign chan_allowed = {status.phase_count == vms_pkg::PHASES_FOUR,
                         status.phase_count != vms_pkg::PHASES_TWO, 2'b11};

  for (genvar c = 1; c <= 4; c++) begin : g_chan
    logic [vms_pkg::CNT_W-1:0] high_cnt;
    logic [vms_pkg::CNT_W-1:0] used_cnt;
    // the cycle now high counts too, else one cycle too many slips past the cap
    assign used_cnt = high_cnt + {7'h00, chan_pulse[c]};
    // a fresh allowance every period caps each pulse at the duty limit
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        high_cnt      <= vms_pkg::CNT_RST;
        chan_pulse[c] <= 1'b0;
      end else if (period_cnt == vms_pkg::PERIOD_LAST) begin
        high_cnt      <= vms_pkg::CNT_RST;
        chan_pulse[c] <= 1'b0;
      end else begin
        chan_pulse[c] <= core_enable & chan_allowed[c] & pwm_demand[c] &
                         (used_cnt < vms_pkg::HIGH_LIMIT);
        if (chan_pulse[c]) begin
          high_cnt <= high_cnt + 8'h01;
        end
      end
    end
  end

  assign phase_pulse_out  = chan_pulse[2:1];
  assign phase3_pulse_out = chan_pulse[3];
  assign phase4_pulse_out = chan_pulse[4];

  // ------------------------------------------------------------
  // power good
  // ------------------------------------------------------------
  logic reset_seen;

  // a reset event holds power good down until enable is cycled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reset_seen <= 1'b0;
    end else if (reset_event) begin
      reset_seen <= 1'b1;
    end else if (!enable_in) begin
      reset_seen <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outputs_power_good <= 1'b0;
    end else begin
      outputs_power_good <= (state == vms_pkg::ST_ON) & enable_in & ~window_fault &
                            ~reset_event & ~reset_seen;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_mode_capture;
    enable_in && !en_q |=> mode == ($past(mode_select_code_bit1) ? vms_pkg::MODE_PARALLEL
                                                                 : vms_pkg::MODE_SERIAL);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("mode not captured");

  property p_mode_hold;
    en_q && enable_in |=> $stable(mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed while on");

  property p_enable_off;
    !enable_in |=> !core_enable && !nb_enable;
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("regulator on while off");

  property p_pg_soft;
    state != vms_pkg::ST_ON |=> !outputs_power_good;
  endproperty
  a_pg_soft: assert property (p_pg_soft) else $error("power good before soft-start");

  property p_pg_fault;
    window_fault || reset_event |=> !outputs_power_good;
  endproperty
  a_pg_fault: assert property (p_pg_fault) else $error("power good during fault");

  property p_duty_limit;
    g_chan[1].high_cnt <= vms_pkg::HIGH_LIMIT;
  endproperty
  a_duty_limit: assert property (p_duty_limit) else $error("duty limit exceeded");

  property p_phase4_off;
    status.phase_count != vms_pkg::PHASES_FOUR |=> !phase4_pulse_out;
  endproperty
  a_phase4_off: assert property (p_phase4_off) else $error("phase 4 pulse unused");

  property p_no_drive_parallel;
    mode == vms_pkg::MODE_PARALLEL |=> !serial_data_code_bit2_oe;
  endproperty
  a_no_drive_parallel: assert property (p_no_drive_parallel)
    else $error("data pin driven in parallel mode");

  property p_droop;
    frequency_set_strap |=> status.droop_en;
  endproperty
  a_droop: assert property (p_droop) else $error("droop not enabled");

  c_parallel: cover property (en_rise && mode_select_code_bit1);
  c_serial_run: cover property (status.serial_run && serial_data_code_bit2_oe);
  c_pg_up: cover property (!outputs_power_good ##1 outputs_power_good);
  c_duty_cut: cover property (pwm_demand[1] && !chan_pulse[1] && core_enable);
endmodule
`default_nettype wire

// *** src/vms_pkg.sv ***
// shared constants and types for the regulator mode-select and status pin block
// assumes a single 50 MHz clock and pins already synchronous to it
`default_nettype none
package vms_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned PWM_PERIOD_NS  = 3000;
  localparam int unsigned PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned DUTY_MAX_PM    = 933;
  // longest high time rounds down so the limit is never exceeded
  localparam int unsigned MAX_HIGH_CYC   = PWM_PERIOD_CYC * DUTY_MAX_PM / 1000;
  localparam int unsigned CNT_W          = 8;
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PWM_PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] HIGH_LIMIT  = CNT_W'(MAX_HIGH_CYC);
  localparam logic [CNT_W-1:0] CNT_RST     = 8'h00;

  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [5:0] REF_CODE_RST  = 6'h00;
  localparam logic [1:0] BOOT_CODE_RST = 2'h0;
  localparam logic [2:0] PHASES_FOUR   = 3'h4;
  localparam logic [2:0] PHASES_THREE  = 3'h3;
  localparam logic [2:0] PHASES_TWO    = 3'h2;

  typedef enum logic {MODE_SERIAL, MODE_PARALLEL} vms_mode_e;
  typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_ON} vms_state_e;

  // shared code pins, bit 5 down to bit 0
  typedef struct packed {
    logic bit5;
    logic bit4;
    logic bit3;
    logic bit2;
    logic bit1;
    logic bit0;
  } vms_pins_s;

  // configuration seen by the regulator core
  typedef struct packed {
    vms_mode_e  mode;
    logic       fixed_voltage_mode;
    logic       serial_run;
    logic       droop_en;
    logic [2:0] phase_count;
  } vms_status_s;
endpackage
`default_nettype wire

// *** testbench/vms_proc_model.sv ***
// processor-side model: drives the shared code pins, the serial clock and the data line
// assumes the bench says which mode was captured and when a serial frame runs
`default_nettype none
module vms_proc_model (
  // clock
  input  wire logic               mclk,
  // bench control
  input  wire vms_pkg::vms_pins_s code,
  input  wire logic               serial_mode,
  input  wire logic               clk_run,
  input  wire logic               proc_drive,
  // device side of the data pin
  input  wire logic               dev_out,
  input  wire logic               dev_oe,
  // pins as the device sees them
  output vms_pkg::vms_pins_s      pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div;
  logic       sclk;
  logic       last;
  initial begin
    div = 2'h0;
    sclk = 1'b0;
    last = 1'b0;
  end
  // ------------------------------------------------------------
  // serial clock: processor only, stands low between frames
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    div <= div + 2'h1;
    if (!clk_run) sclk <= 1'b0;
    else if (div == 2'h3) sclk <= ~sclk;
  end
  // ------------------------------------------------------------
  // data line: device or processor; no pull in serial mode, so a
  // released line wanders instead of keeping its last level
  // ------------------------------------------------------------
  always_comb begin
    pins = code;
    if (serial_mode) begin
      pins.bit3 = sclk;
      if (dev_oe) pins.bit2 = dev_out;
      else if (proc_drive) pins.bit2 = code.bit2;
      else pins.bit2 = ~last;
    end
  end
  always @(posedge mclk) last <= pins.bit2;
endmodule
`default_nettype wire

// *** testbench/test_vms_mode_status.sv ***
// self-checking bench for the mode-select and status pin block
// assumes the processor model beside it and a 50 MHz clock
`default_nettype none
module test_vms_mode_status;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 mclk, rst, enable_in, power_ok, fs_strap, clk_run, proc_drive;
  logic [4:1]           sense_sup, demand;
  logic                 soft_done, win_fault, rst_event, link_out, link_drive;
  vms_pkg::vms_pins_s   code, pins;
  logic                 d_out, d_oe, link_in, link_clk, core_en, nb_en, pg, ph3, ph4;
  logic [5:0]           ref_code;
  logic [1:0]           boot_code;
  vms_pkg::vms_status_s status;
  logic [2:1]           ph12;
  int                   failures, n_checks;
  // ------------------------------------------------------------
  // design and far side
  // ------------------------------------------------------------
  vms_mode_status i_dut (.mclk(mclk), .rst(rst), .enable_in(enable_in),
    .system_power_ok(power_ok), .frequency_set_strap(fs_strap),
    .current_sense_neg_at_supply(sense_sup), .mode_select_code_bit1(pins.bit1),
    .fixed_mode_sel_code_bit0(pins.bit0), .serial_data_code_bit2_in(pins.bit2),
    .serial_data_code_bit2_out(d_out), .serial_data_code_bit2_oe(d_oe),
    .serial_clock_code_bit3(pins.bit3), .parallel_code_bit4(pins.bit4),
    .parallel_code_bit5(pins.bit5), .link_data_out(link_out), .link_data_drive(link_drive),
    .link_data_in(link_in), .link_clock_in(link_clk), .soft_start_done(soft_done),
    .window_fault(win_fault), .reset_event(rst_event), .pwm_demand(demand),
    .core_enable(core_en), .nb_enable(nb_en), .ref_code(ref_code), .boot_code(boot_code),
    .status(status), .phase_pulse_out(ph12), .phase3_pulse_out(ph3),
    .phase4_pulse_out(ph4), .outputs_power_good(pg));
  vms_proc_model i_proc (.mclk(mclk), .code(code),
    .serial_mode(status.mode == vms_pkg::MODE_SERIAL),
    .clk_run(clk_run), .proc_drive(proc_drive), .dev_out(d_out), .dev_oe(d_oe), .pins(pins));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // mode is only caught on a fresh rise, so always drop enable first
  task automatic start(input logic sel);
    enable_in = 1'b0;
    cyc(3);
    code.bit1 = sel;
    cyc(1);
    enable_in = 1'b1;
    cyc(3);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_parallel();
    code = 6'h2B;
    start(1'b1);
    check("mode", status.mode, vms_pkg::MODE_PARALLEL);
    check("enables", {core_en, nb_en}, 2'h3);
    check("ref", ref_code, 6'h2B);
    code = 6'h30;
    link_drive = 1'b1;
    cyc(3);
    check("mode_hold", status.mode, vms_pkg::MODE_PARALLEL);
    check("ref_b45", ref_code, 6'h30);
    check("oe_par", d_oe, 1'b0);
    link_drive = 1'b0;
    enable_in = 1'b0;
    cyc(3);
    check("disabled", {core_en, nb_en}, 2'h0);
  endtask
  task automatic t_serial();
    logic [5:0] held;
    code = 6'h05;
    power_ok = 1'b0;
    start(1'b0);
    check("mode", status.mode, vms_pkg::MODE_SERIAL);
    check("fixed", status.fixed_voltage_mode, 1'b1);
    check("boot", boot_code, 2'h2);
    check("run_off", status.serial_run, 1'b0);
    held = ref_code;
    code = 6'h34;
    power_ok = 1'b1;
    cyc(3);
    check("fixed_off", status.fixed_voltage_mode, 1'b0);
    check("ref_ser", ref_code, held);
    check("run_on", status.serial_run, 1'b1);
    check("data_in", link_in, 1'b1);
    proc_drive = 1'b0;
    link_drive = 1'b1;
    cyc(3);
    check("oe_on", {d_oe, link_in}, 2'h2);
    link_drive = 1'b0;
    proc_drive = 1'b1;
    cyc(3);
    check("oe_off", {d_oe, link_in}, 2'h1);
    clk_run = 1'b1;
    held = 6'h00;
    repeat (40) begin
      @(negedge mclk);
      if (link_clk && held[0] == 1'b0) held[5:1] = held[5:1] + 5'h01;
      held[0] = link_clk;
    end
    clk_run = 1'b0;
    check("sclk_rises", held[5:1] != 5'h00, 1'b1);
  endtask
  task automatic t_power_good();
    soft_done = 1'b0;
    start(1'b1);
    cyc(10);
    check("pg_soft", pg, 1'b0);
    soft_done = 1'b1;
    cyc(4);
    check("pg_on", pg, 1'b1);
    win_fault = 1'b1;
    cyc(2);
    check("pg_window", pg, 1'b0);
    win_fault = 1'b0;
    cyc(3);
    check("pg_back", pg, 1'b1);
    rst_event = 1'b1;
    cyc(1);
    rst_event = 1'b0;
    cyc(5);
    check("pg_sticky", pg, 1'b0);
    start(1'b1);
    cyc(2);
    check("pg_rearm", pg, 1'b1);
  endtask
  task automatic t_phases();
    int run, longest, n2, n3, n4, lim;
    lim = 150 * 933 / 1000;
    for (int i = 0; i < 3; i++) begin
      fs_strap = i[0];
      sense_sup = (i == 2) ? 4'h0 : 4'(4'h4 << i);
      demand = 4'h0;
      start(1'b1);
      check("droop", status.droop_en, i[0]);
      check("phases", status.phase_count, 8'(i + 2));
      demand = 4'hF;
      run = 0;
      longest = 0;
      n2 = 0;
      n3 = 0;
      n4 = 0;
      repeat (320) begin
        @(negedge mclk);
        run = (ph12[1] === 1'b1) ? run + 1 : 0;
        if (run > longest) longest = run;
        n2 += (ph12[2] === 1'b1);
        n3 += (ph3 === 1'b1);
        n4 += (ph4 === 1'b1);
      end
      check("duty", longest <= lim && longest > lim / 2, 1'b1);
      check("ph2", n2 != 0, 1'b1);
      check("ph3", n3 != 0, i >= 1);
      check("ph4", n4 != 0, i == 2);
    end
  endtask
  // ------------------------------------------------------------
  // clock, sequence, watchdog
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    failures = 0;
    n_checks = 0;
    rst = 1'b1;
    {enable_in, power_ok, fs_strap, clk_run, soft_done, win_fault, rst_event} = 7'h00;
    {link_out, link_drive, sense_sup, demand} = 10'h000;
    proc_drive = 1'b1;
    code = 6'h00;
    cyc(6);
    rst = 1'b0;
    cyc(2);
    check("after_rst", {core_en, nb_en, pg}, 3'h0);
    t_parallel();
    t_serial();
    t_power_good();
    t_phases();
    finish_test();
  end
  // about 1100 cycles are needed; an 18-fold margin still ends a hang quickly
  initial begin
    #(20 * 20000);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
